/* File: pkg/spsc_pkg.sv */
// spsc_pkg: register map, field positions and widths for the serial port status block
// assumes a 32-bit avalon-mm slave with word offsets as byte addresses
package spsc_pkg;
    localparam int          SPSC_DATA_W     = 16;
    localparam int          SPSC_BYTE_W     = 8;
    localparam logic [3:0]  SPSC_ADR_STATUS = 4'h0;
    localparam logic [3:0]  SPSC_ADR_DATA   = 4'h4;
    localparam logic [3:0]  SPSC_ADR_CTRL   = 4'h8;
    localparam logic [3:0]  SPSC_ADR_IRQ_ST = 4'hC;
    localparam logic [3:0]  SPSC_ADR_IRQ_MK = 4'h0;
    localparam int          SPSC_ADR_W      = 4;
    localparam int          SPSC_EN_BIT     = 15;
    localparam int          SPSC_SIDL_BIT   = 13;
    localparam int          SPSC_ROV_BIT    = 6;
    localparam int          SPSC_TBF_BIT    = 1;
    localparam int          SPSC_RBF_BIT    = 0;
    localparam int          SPSC_W16_BIT    = 0;
    localparam int          SPSC_MST_BIT    = 1;
    localparam int          SPSC_DIV_BIT    = 8;
    localparam int          SPSC_DIV_W      = 8;
    localparam int          SPSC_IRQ_W      = 3;
    localparam logic [7:0]  SPSC_DIV_RESET  = 8'h04;
    localparam logic [15:0] SPSC_ZERO16     = 16'h0000;
    localparam logic [31:0] SPSC_ZERO32     = 32'h0000_0000;
endpackage

/* File: rtl/spsc_sync3.sv */
// spsc_sync3: three-stage synchroniser for pins from outside the ref_clk domain
// assumes async inputs; the output changes once stages two and three agree
`timescale 1ns/1ps
module spsc_sync3
(
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic din,
    output logic      dout
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            dout <= 1'b0;
        else if (s2 == s3)
            dout <= s3;
    end
endmodule

/* File: rtl/spsc_core.sv */
// spsc_core: serial port status/control, buffers, 16-bit shifter and avalon-mm slave
// assumes avalon-mm master on ref_clk; serial pins are asynchronous and resynchronised
//
// Overview of operation
// [R1] enable bit 15 starts the port and hands pins to serial use; clear disables
// [R2] idle stop bit 13 set halts the module while the device idles
// [R3] overflow bit 6 sets when a unit completes with unread data; new data lost
// [R4] writing the data buffer sets transmit full bit 1
// [R5] moving holding buffer into shifter clears transmit full
// [R6] completed unit moved into receive buffer sets receive full bit 0
// [R7] reading the data buffer clears receive full
// [R8] status bits 14, 12..7 and 5..2 read zero
// [R9] shifter is sixteen bits behind a separate cpu buffer
// [R10] width select picks 16-bit or 8-bit units
// [R11] reset clears every status and control bit; the code loads the clock divider field with 4 instead
`timescale 1ns/1ps
module spsc_core
    import spsc_pkg::*;
#(
    parameter int DATA_W = SPSC_DATA_W
)
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        device_idle,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    output logic             sdo_out,
    output logic             sdo_oe,
    input  wire logic        sdi_in,
    input  wire logic        ss_n_in,
    output logic             pins_serial,
    output logic             irq
);
    typedef enum logic [1:0] {SPSC_IDLE, SPSC_SHIFT, SPSC_DONE} spsc_state_type;

    spsc_state_type state;
    logic              port_module_enable;
    logic              idle_stop_select;
    logic              receive_overflow_flag;
    logic              transmit_buffer_full_flag;
    logic              receive_buffer_full_flag;
    logic              word_width_select;
    logic              master_mode;
    logic [SPSC_DIV_W-1:0] clk_div;
    logic [SPSC_DIV_W-1:0] div_cnt;
    logic [DATA_W-1:0] transmit_holding_buffer;
    logic [DATA_W-1:0] receive_holding_buffer;
    logic [DATA_W-1:0] serial_shift_register;
    logic [4:0]        bit_cnt;
    logic [SPSC_IRQ_W-1:0] irq_status;
    logic [SPSC_IRQ_W-1:0] irq_mask;
    logic              ack;
    logic              sck_sync;
    logic              sdi_sync;
    logic              ss_n_sync;
    logic              sck_prev;
    logic              sck_int;
    logic              run;
    logic              sck_rise;
    logic              sck_fall;
    logic              wr_data;
    logic              rd_data;
    logic              load_tx;
    logic              slave_start;
    logic              unit_done;
    logic [4:0]        unit_len;
    logic [DATA_W-1:0] status_word;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        hit = (a == b);
    endfunction

    spsc_sync3 u_sync_sck (.ref_clk(ref_clk), .rstn(rstn), .din(sck_in), .dout(sck_sync));
    spsc_sync3 u_sync_sdi (.ref_clk(ref_clk), .rstn(rstn), .din(sdi_in), .dout(sdi_sync));
    spsc_sync3 u_sync_ss (.ref_clk(ref_clk), .rstn(rstn), .din(ss_n_in), .dout(ss_n_sync));

    // one-cycle wait on every access so read data always come from a register
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_data = avs_write & ~ack & hit(avs_address, SPSC_ADR_DATA);
    assign rd_data = avs_read & ~ack & hit(avs_address, SPSC_ADR_DATA);

    assign run = port_module_enable & ~(idle_stop_select & device_idle); // R1 R2
    assign pins_serial = port_module_enable; // R1
    assign unit_len = word_width_select ? 5'(DATA_W) : 5'(SPSC_BYTE_W); // R10
    assign sck_oe = port_module_enable & master_mode;
    assign sdo_oe = port_module_enable & (master_mode | ~ss_n_sync);

    assign status_word = {port_module_enable, 1'b0, idle_stop_select, 6'b00_0000, // R8
                          receive_overflow_flag, 4'b0000,
                          transmit_buffer_full_flag, receive_buffer_full_flag};

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            ack <= 1'b0;
        else
            ack <= (avs_read | avs_write) & ~ack;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            avs_readdata <= SPSC_ZERO32;
        else if (avs_read & ~ack)
        begin
            if (hit(avs_address, SPSC_ADR_STATUS))
                avs_readdata <= {SPSC_ZERO16, status_word};
            else if (hit(avs_address, SPSC_ADR_DATA))
                avs_readdata <= {SPSC_ZERO16, receive_holding_buffer};
            else if (hit(avs_address, SPSC_ADR_CTRL))
                avs_readdata <= {SPSC_ZERO16, clk_div, 6'b00_0000, master_mode,
                                 word_width_select};
            else if (hit(avs_address, SPSC_ADR_IRQ_ST))
                avs_readdata <= {29'h0000_0000, irq_status};
            else
                avs_readdata <= {29'h0000_0000, irq_mask};
        end
    end

    // mask is written through the unused upper half of the irq status word and reads back at unmapped addresses
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            port_module_enable <= 1'b0; // R11
            idle_stop_select   <= 1'b0;
            word_width_select  <= 1'b0;
            master_mode        <= 1'b0;
            clk_div            <= SPSC_DIV_RESET;
            irq_mask           <= '0;
        end
        else if (avs_write & ~ack)
        begin
            if (hit(avs_address, SPSC_ADR_STATUS))
            begin
                port_module_enable <= avs_writedata[SPSC_EN_BIT]; // R1
                idle_stop_select   <= avs_writedata[SPSC_SIDL_BIT]; // R2
            end
            else if (hit(avs_address, SPSC_ADR_CTRL))
            begin
                word_width_select <= avs_writedata[SPSC_W16_BIT]; // R10
                master_mode       <= avs_writedata[SPSC_MST_BIT];
                clk_div           <= avs_writedata[SPSC_DIV_BIT +: SPSC_DIV_W];
            end
            else if (hit(avs_address, SPSC_ADR_IRQ_ST))
                irq_mask <= avs_writedata[SPSC_DATA_W +: SPSC_IRQ_W];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            transmit_holding_buffer <= '0;
        else if (wr_data)
            transmit_holding_buffer <= avs_writedata[DATA_W-1:0];
    end

    // internal master clock; slaves follow the synchronised pin
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_cnt <= '0;
            sck_int <= 1'b0;
        end
        else if (state != SPSC_SHIFT || !master_mode || !run)
        begin
            div_cnt <= '0;
            sck_int <= 1'b0;
        end
        else if (div_cnt >= clk_div)
        begin
            div_cnt <= '0;
            sck_int <= ~sck_int;
        end
        else
            div_cnt <= div_cnt + 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            sck_prev <= 1'b0;
        else
            sck_prev <= master_mode ? sck_int : sck_sync;
    end

    assign sck_rise = ~sck_prev & (master_mode ? sck_int : sck_sync);
    assign sck_fall = sck_prev & ~(master_mode ? sck_int : sck_sync);
    assign sck_out  = sck_int;
    assign load_tx  = run && state == SPSC_IDLE && transmit_buffer_full_flag &&
                      (master_mode || !ss_n_sync);
    // a selected slave must clock in even with nothing queued to send
    assign slave_start = run && state == SPSC_IDLE && !master_mode && !ss_n_sync;
    assign unit_done = run && state == SPSC_DONE;

    // shift out msb first on falling edges, sample on rising edges
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state                 <= SPSC_IDLE;
            serial_shift_register <= '0;
            bit_cnt               <= '0;
            sdo_out               <= 1'b0;
        end
        else if (!port_module_enable)
            state <= SPSC_IDLE;
        else if (run)
        begin
            case (state)
                SPSC_IDLE:
                    if (load_tx) // R5 R9
                    begin
                        serial_shift_register <= word_width_select ? transmit_holding_buffer
                            : {transmit_holding_buffer[SPSC_BYTE_W-1:0], 8'h00};
                        sdo_out <= word_width_select ? transmit_holding_buffer[DATA_W-1]
                            : transmit_holding_buffer[SPSC_BYTE_W-1];
                        bit_cnt <= '0;
                        state   <= SPSC_SHIFT;
                    end
                    else if (slave_start) // R3 R6
                    begin
                        sdo_out <= serial_shift_register[DATA_W-1];
                        bit_cnt <= '0;
                        state   <= SPSC_SHIFT;
                    end
                SPSC_SHIFT:
                    // a deselect mid-unit drops the partial word
                    if (!master_mode && ss_n_sync)
                        state <= SPSC_IDLE;
                    else if (sck_rise)
                    begin
                        serial_shift_register <= {serial_shift_register[DATA_W-2:0], sdi_sync};
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt + 1'b1 == unit_len) // R10
                            state <= SPSC_DONE;
                    end
                    else if (sck_fall)
                        sdo_out <= serial_shift_register[DATA_W-1];
                SPSC_DONE:
                    state <= SPSC_IDLE;
                default:
                    state <= SPSC_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            receive_holding_buffer <= '0;
        else if (unit_done && !receive_buffer_full_flag) // R3 R6
            receive_holding_buffer <= word_width_select ? serial_shift_register
                : {8'h00, serial_shift_register[SPSC_BYTE_W-1:0]};
    end

    // data-write set wins over a same-cycle load clear
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            transmit_buffer_full_flag <= 1'b0; // R11
        else if (wr_data)
            transmit_buffer_full_flag <= 1'b1; // R4
        else if (load_tx)
            transmit_buffer_full_flag <= 1'b0; // R5
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            receive_buffer_full_flag <= 1'b0; // R11
        else if (unit_done && !receive_buffer_full_flag)
            receive_buffer_full_flag <= 1'b1; // R6
        else if (rd_data)
            receive_buffer_full_flag <= 1'b0; // R7
    end

    // overflow clears by writing zero to bit 6 of the status word
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            receive_overflow_flag <= 1'b0; // R11
        else if (unit_done && receive_buffer_full_flag)
            receive_overflow_flag <= 1'b1; // R3
        else if (avs_write && !ack && hit(avs_address, SPSC_ADR_STATUS) &&
                 !avs_writedata[SPSC_ROV_BIT])
            receive_overflow_flag <= 1'b0;
    end

    // events: 0 receive full, 1 transmit empty, 2 overflow; write one to clear
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            irq_status <= '0;
        else
            irq_status <= (irq_status & ~((avs_write && !ack &&
                            hit(avs_address, SPSC_ADR_IRQ_ST)) ?
                            avs_writedata[SPSC_IRQ_W-1:0] : 3'b000))
                          | {unit_done & receive_buffer_full_flag,
                             load_tx,
                             unit_done & ~receive_buffer_full_flag};
    end

    assign irq = |(irq_status & irq_mask);

    a_tbf_on_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R4
        wr_data |=> transmit_buffer_full_flag)
        else $error("transmit full not set by data write");
    a_tbf_clear: assert property (@(posedge ref_clk) disable iff (!rstn) // R5
        (load_tx && !wr_data) |=> !transmit_buffer_full_flag && state == SPSC_SHIFT)
        else $error("transmit full not cleared on load");
    a_rbf_set: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
        (unit_done && !receive_buffer_full_flag) |=> receive_buffer_full_flag)
        else $error("receive full not set");
    a_rbf_read: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
        (rd_data && !unit_done) |=> !receive_buffer_full_flag)
        else $error("receive full not cleared by read");
    a_ovf_keep: assert property (@(posedge ref_clk) disable iff (!rstn) // R3
        (unit_done && receive_buffer_full_flag) |=>
        receive_overflow_flag && $stable(receive_holding_buffer))
        else $error("overflow not flagged or data overwritten");
    a_zero_bits: assert property (@(posedge ref_clk) disable iff (!rstn) // R8
        (avs_read && !ack && hit(avs_address, SPSC_ADR_STATUS)) |=>
        (avs_readdata & 32'hFFFF_5FBC) == SPSC_ZERO32)
        else $error("unimplemented status bits not zero");
    a_idle_halt: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
        (idle_stop_select && device_idle && state == SPSC_SHIFT) |=> $stable(bit_cnt))
        else $error("shifter ran in idle stop");
    a_disable_idle: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
        !port_module_enable |-> (!pins_serial && !sdo_oe && !sck_oe) ##1
        (state == SPSC_IDLE))
        else $error("disabled module not idle");
    a_byte_len: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
        (state == SPSC_SHIFT && sck_rise && run) |-> bit_cnt < unit_len)
        else $error("unit length exceeded");
    a_cut_frame: assert property (@(posedge ref_clk) disable iff (!rstn) // R9
        (state == SPSC_SHIFT && run && !master_mode && ss_n_sync) |=> state == SPSC_IDLE)
        else $error("deselected slave kept shifting");
endmodule

/* File: verif/spsc_far_end.sv */
// spsc_far_end: behavioural external serial controller that clocks the port as its slave
// assumes the port is in slave mode; mode 0, msb first, link clock period 400 ns
`timescale 1ns/1ps
module spsc_far_end
(
    output logic      sck,
    output logic      sdi,
    output logic      ss_n,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    initial
    begin
        sck = 1'b0;
        sdi = 1'b0;
        ss_n = 1'b1;
    end

    // clock stands low outside frames; offset keeps pin edges off the ref_clk edge
    task automatic frame(input int nbits, input logic [15:0] tx, output logic [15:0] got);
        got = 16'h0000;
        #7;
        ss_n = 1'b0;
        #400;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sdi = tx[i];
            #200;
            sck = 1'b1;
            #200;
            // the port answers a falling edge only after resynchronising: sample late
            got = {got[14:0], sdo_oe ? sdo : 1'bx};
            sck = 1'b0;
        end
        #200;
        ss_n = 1'b1;
        // released data line: show the inverse so a stale value is never mistaken
        sdi = ~sdi;
        #393;
    endtask
endmodule

/* File: verif/testbench.sv */
// testbench: drives the port over avalon-mm and the serial pins through spsc_far_end
// assumes spsc_core answers a request by lowering waitrequest at some rising edge
`timescale 1ns/1ps
module testbench
    import spsc_pkg::*;
();
    logic        ref_clk;
    logic        rstn;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        device_idle;
    logic        link_sck;
    logic        link_sdi;
    logic        link_ss_n;
    logic        sdo_out;
    logic        sdo_oe;
    logic        pins_serial;
    logic        irq;
    logic [15:0] lfsr;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [15:0] mask;
    logic [15:0] seen;
    logic        sck_out;
    logic        sck_oe;
    int          n_sck;
    int          n_mismatch;
    int          checks_done;
    int          cycles;

    spsc_core dut_u (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .device_idle(device_idle), .sck_in(link_sck), .sck_out(sck_out), .sck_oe(sck_oe),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdi_in(link_sdi), .ss_n_in(link_ss_n),
        .pins_serial(pins_serial), .irq(irq));

    spsc_far_end far_u (.sck(link_sck), .sdi(link_sdi), .ss_n(link_ss_n),
        .sdo(sdo_out), .sdo_oe(sdo_oe));

    always #25 ref_clk = ~ref_clk;

    // counts the port's own clock pulses while it is link master
    always @(posedge sck_out)
        n_sck <= n_sck + 1;

    // ceiling well above the roughly 1550 cycles the sequence needs
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // f = {enable, idle stop, overflow, tx full, rx full}; all other bits read zero
    function automatic logic [31:0] exp_stat(input logic [4:0] f);
        logic [31:0] s;
        s = 32'h0000_0000;
        s[SPSC_EN_BIT] = f[4];
        s[SPSC_SIDL_BIT] = f[3];
        s[SPSC_ROV_BIT] = f[2];
        s[SPSC_TBF_BIT] = f[1];
        s[SPSC_RBF_BIT] = f[0];
        return s;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request stands until waitrequest is seen low at a rising edge
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                            output logic [31:0] rd);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus_xfer(1'b1, a, d, unused);
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] got;
        bus_xfer(1'b0, a, 32'h0000_0000, got);
        chk(what, exp, got);
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        device_idle = 1'b0;
        lfsr = 16'h31bb;
        n_mismatch = 0;
        checks_done = 0;
        cycles = 0;
        n_sck = 0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        rd_chk("status after reset", SPSC_ADR_STATUS, 32'h0000_0000);
        rd_chk("ctrl after reset", SPSC_ADR_CTRL, {16'h0000, SPSC_DIV_RESET, 8'h00});
        chk("pins_serial after reset", 32'h0000_0000, {31'h0, pins_serial});
        tx = rnd();
        wr(SPSC_ADR_DATA, {16'h0000, tx});
        rd_chk("status after data write", SPSC_ADR_STATUS, exp_stat(5'b00010));
        wr(SPSC_ADR_STATUS, 32'h0000_ffff);
        rd_chk("status enabled", SPSC_ADR_STATUS, exp_stat(5'b11010));
        chk("pins_serial enabled", 32'h0000_0001, {31'h0, pins_serial});
        for (int i = 0; i < 4; i++)
        begin
            mask = i[0] ? 16'hffff : 16'h00ff;
            rx = rnd();
            wr(SPSC_ADR_CTRL, {16'h0000, SPSC_DIV_RESET, 7'h00, i[0]});
            if (i > 0)
            begin
                tx = rnd();
                wr(SPSC_ADR_DATA, {16'h0000, tx});
            end
            far_u.frame(i[0] ? 16 : 8, rx, seen);
            chk("serial out bits", {16'h0000, tx & mask}, {16'h0000, seen & mask});
            chk("irq masked", 32'h0000_0000, {31'h0, irq});
            rd_chk("status after frame", SPSC_ADR_STATUS, exp_stat(5'b11001));
            rd_chk("received data", SPSC_ADR_DATA, {16'h0000, rx & mask});
            rd_chk("status after read", SPSC_ADR_STATUS, exp_stat(5'b11000));
        end
        rx = rnd();
        far_u.frame(16, rx, seen);
        far_u.frame(16, rnd(), seen);
        rd_chk("status after overrun", SPSC_ADR_STATUS, exp_stat(5'b11101));
        rd_chk("data kept on overrun", SPSC_ADR_DATA, {16'h0000, rx});
        wr(SPSC_ADR_STATUS, 32'h0000_a000);
        rd_chk("status after clear", SPSC_ADR_STATUS, exp_stat(5'b11000));
        wr(SPSC_ADR_IRQ_ST, 32'h0001_0007);
        chk("irq after clear", 32'h0000_0000, {31'h0, irq});
        rx = rnd();
        far_u.frame(16, rx, seen);
        chk("irq on receive", 32'h0000_0001, {31'h0, irq});
        rd_chk("received data", SPSC_ADR_DATA, {16'h0000, rx});
        wr(SPSC_ADR_IRQ_ST, 32'h0001_0001);
        chk("irq after w1c", 32'h0000_0000, {31'h0, irq});
        device_idle <= 1'b1;
        far_u.frame(16, rnd(), seen);
        rd_chk("status halted in idle", SPSC_ADR_STATUS, exp_stat(5'b11000));
        wr(SPSC_ADR_STATUS, 32'h0000_0000);
        chk("pins_serial disabled", 32'h0000_0000, {31'h0, pins_serial});
        wr(SPSC_ADR_STATUS, 32'h0000_8000);
        rx = rnd();
        far_u.frame(16, rx, seen);
        rd_chk("status running in idle", SPSC_ADR_STATUS, exp_stat(5'b10001));
        rd_chk("data received in idle", SPSC_ADR_DATA, {16'h0000, rx});
        device_idle <= 1'b0;
        wr(SPSC_ADR_CTRL, {16'h0000, SPSC_DIV_RESET, 8'h02});
        tx = rnd();
        wr(SPSC_ADR_DATA, {16'h0000, tx});
        repeat (200) @(posedge ref_clk);
        chk("sck pulses as master", 32'h0000_0008, n_sck);
        chk("sck_oe as master", 32'h0000_0001, {31'h0, sck_oe});
        rd_chk("status after master unit", SPSC_ADR_STATUS, exp_stat(5'b10001));
        tally_and_finish();
    end
endmodule
